// *** logic/bcid_decoder.sv ***
// Byte-code instruction decoder with a classic Wishbone register slave
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module bcid_decoder
  import bcid_pkg::*;
(
  input wire logic clk_sys, // Core clock, 10 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic [1:0] insnLen, // Decoded length in bytes
  output logic [2:0] insnCycles, // Decoded machine cycles
  output logic [15:0] branchTarget, // Decoded branch target
  output logic irqVectorReady // Service routine may start
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [23:0] insn;
    logic [15:0] pc;
    logic [19:0] opnd;
    logic [DEC_W-1:0] dec;
    logic [31:0] tgt;
    logic [18:0] res;
    logic [6:0] irqCnt;
    logic irqBusy;
    logic irqDone;
  } bcid_state_s;

  bcid_state_s st_q, st_d;
  logic [1:0] rstPipe_q;
  logic rstN;
  logic [7:0] op, b2, b3, acc, ram, relByte;
  logic [3:0] hi, lo, ent;
  logic [1:0] len, bank;
  logic [2:0] cyc;
  logic [5:0] fmask;
  logic [4:0] regAddr;
  logic [15:0] follow, target;
  logic [7:0] accN, ramN;
  logic carry, bitVal, carN, brN, bclrN, relBr, valid;
  logic [6:0] latency;
  logic wbReq;
  bcid_mode_e mode;

  // Release reset through two flops so the whole block leaves reset on one edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe_q <= 2'b00;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstN = rstPipe_q[1];

  // Byte-lane merge for partial writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : laneMerge

  // Decode, datapath effects, interrupt timing and bus slave
  always_comb begin
    st_d = st_q;
    op = st_q.insn[7:0];
    b2 = st_q.insn[15:8];
    b3 = st_q.insn[23:16];
    hi = op[7:4];
    lo = op[3:0];
    acc = st_q.opnd[7:0];
    ram = st_q.opnd[15:8];
    carry = st_q.opnd[16];
    bitVal = st_q.opnd[17];
    bank = st_q.opnd[19:18];
    // Table lookup by low nibble, entry by high nibble
    case (lo)
      4'h0: ent = TBL_LO0[4*hi +: 4];
      4'h1: ent = TBL_LO1[4*hi +: 4];
      4'h2: ent = TBL_LO2[4*hi +: 4];
      4'h3: ent = TBL_LO3[4*hi +: 4];
      4'h4: ent = TBL_LO4[4*hi +: 4];
      4'h5: ent = TBL_LO5[4*hi +: 4];
      4'h6, 4'h7: ent = TBL_LOI[4*hi +: 4];
      default: ent = TBL_LOR[4*hi +: 4];
    endcase
    len = ent[3:2];
    cyc = 3'(ent[1:0]) + 3'h1;
    valid = (len != 2'h0); // Reserved opcode decodes with zero length
    // Relative branches: bit tests, flag tests, short jump, compare and decrement forms
    relBr = (lo == 4'h0 && hi >= 4'h1 && hi <= 4'h8) || (hi == 4'hb && lo >= 4'h4)
      || (hi == 4'hd && (lo == 4'h5 || op[3]));
    // Primary operand mode
    if (lo == 4'h1) begin
      mode = MODE_PAGE;
    end else if (op == 8'h02 || op == 8'h12) begin
      mode = MODE_LONG;
    end else if (op == 8'h90) begin
      mode = MODE_IMM16;
    end else if ((hi >= 4'he) && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3)) begin
      mode = MODE_EXT;
    end else if (op == 8'h73 || op == 8'h83 || op == 8'h93) begin
      mode = MODE_CODE;
    end else if (op[3]) begin
      mode = MODE_REG;
    end else if (lo == 4'h6 || lo == 4'h7) begin
      mode = MODE_INDIRECT;
    end else if ((lo == 4'h2 && hi >= 4'h7 && hi <= 4'hd) || (lo == 4'h0 && hi >= 4'h1 && hi <= 4'h3)
      || (lo == 4'h0 && (hi == 4'ha || hi == 4'hb))) begin
      mode = MODE_BIT;
    end else if (lo == 4'h5 || (lo == 4'h3 && hi >= 4'h4 && hi <= 4'h6) || (lo == 4'h2 && hi >= 4'h4)
      || (lo == 4'h0 && (hi == 4'hc || hi == 4'hd))) begin
      mode = MODE_DIRECT;
    end else if (lo == 4'h4 && ((hi >= 4'h2 && hi <= 4'h7) || hi == 4'h9 || hi == 4'hb)) begin
      mode = MODE_IMM;
    end else if (relBr) begin
      mode = MODE_REL;
    end else begin
      mode = MODE_NONE;
    end
    // Register file address of a working register or pointer register
    regAddr = (mode == MODE_INDIRECT || (mode == MODE_EXT && lo != 4'h0)) ? {bank, 2'b00, op[0]}
      : {bank, op[2:0]};
    // Flag effects
    fmask = 6'h00;
    if (hi == 4'h2 || hi == 4'h3 || hi == 4'h9) begin
      if (lo >= 4'h4) begin
        fmask = 6'h1c;
      end
    end
    if (op == 8'ha4 || op == 8'h84) begin
      fmask = 6'h0a;
    end
    if (op == 8'hd4 || op == 8'h13 || op == 8'h33 || (hi == 4'hb && lo >= 4'h4) || op == 8'hb3
      || op == 8'h72 || op == 8'h82 || op == 8'ha0 || op == 8'hb0 || op == 8'ha2) begin
      fmask = 6'h04;
    end
    if (op == 8'hd3) begin
      fmask = 6'h01;
    end
    if (op == 8'hc3) begin
      fmask = 6'h02;
    end
    // A direct-mode touch of the status word byte or a bit-mode touch of one of its bits also updates flags
    if ((mode == MODE_DIRECT && (op == 8'h85 ? b3 : b2) == SW_BYTE) || (mode == MODE_BIT && b2[7:3] == SW_BITPAGE)) begin
      fmask[FM_SW] = 1'b1;
    end
    // Branch targets from the address of the byte after the instruction; the long form is absolute
    follow = st_q.pc + 16'(len);
    relByte = (len == 2'h3) ? b3 : b2;
    case (mode)
      MODE_PAGE: target = {follow[15:11], op[7:5], b2};
      MODE_LONG: target = {b2, b3};
      default: target = follow + {{8{relByte[7]}}, relByte};
    endcase
    // Datapath effects the decoder resolves itself
    accN = acc;
    ramN = ram;
    carN = carry;
    brN = 1'b0;
    bclrN = 1'b0;
    case (op)
      8'hc4: accN = {acc[3:0], acc[7:4]};
      8'hd6, 8'hd7: begin
        accN = {acc[7:4], ram[3:0]};
        ramN = {ram[7:4], acc[3:0]};
      end
      8'h33: begin
        accN = {acc[6:0], carry};
        carN = acc[7];
      end
      8'h13: begin
        accN = {carry, acc[7:1]};
        carN = acc[0];
      end
      8'h23: accN = {acc[6:0], acc[7]};
      8'h03: accN = {acc[0], acc[7:1]};
      8'hd3: carN = 1'b1;
      8'hc3: carN = 1'b0;
      8'hb3: carN = ~carry;
      8'h10: begin
        brN = bitVal;
        bclrN = bitVal;
      end
      8'h20: brN = bitVal;
      8'h30: brN = ~bitVal;
      8'h40: brN = carry;
      8'h50: brN = ~carry;
      8'h60: brN = (acc == 8'h00);
      8'h70: brN = (acc != 8'h00);
      8'h80: brN = 1'b1;
      8'hb4: brN = (acc != b2);
      default: brN = 1'b0;
    endcase
    st_d.dec = {valid, relBr, fmask, (mode == MODE_INDIRECT), regAddr, 4'(mode), cyc, len};
    st_d.tgt = {follow, target};
    st_d.res = {bclrN, brN, carN, ramN, accN};
    // Response window: finish the current instruction, then respond and push
    latency = IRQ_MIN_OSC + 7'(OSC_PER_MCYC * 7'(cyc - 3'h1));
    if (latency > IRQ_MAX_OSC) begin
      latency = IRQ_MAX_OSC;
    end
    if (st_q.irqBusy) begin
      st_d.irqCnt = st_q.irqCnt - 7'h01;
      if (st_q.irqCnt == 7'h01) begin
        st_d.irqBusy = 1'b0;
        st_d.irqDone = 1'b1;
      end
    end
    // Bus slave: ack one cycle after the request, dropped the cycle after
    wbReq = wb_cyc_i && wb_stb_i && !st_q.ack;
    st_d.ack = wbReq;
    st_d.rdat = 32'h00000000;
    if (wbReq && wb_we_i) begin
      case (wb_adr_i)
        ADR_INSN: st_d.insn = 24'(laneMerge({8'h00, st_q.insn}, wb_dat_i, wb_sel_i));
        ADR_PC: st_d.pc = 16'(laneMerge({16'h0000, st_q.pc}, wb_dat_i, wb_sel_i));
        ADR_OPND: st_d.opnd = 20'(laneMerge({12'h000, st_q.opnd}, wb_dat_i, wb_sel_i));
        ADR_IRQ: begin
          // A request while one is pending is ignored; the old one keeps its timing
          if (wb_sel_i[0] && wb_dat_i[0] && !st_q.irqBusy) begin
            st_d.irqBusy = 1'b1;
            st_d.irqDone = 1'b0;
            st_d.irqCnt = latency;
          end
        end
        default: st_d.rdat = 32'h00000000;
      endcase
    end else if (wbReq) begin
      case (wb_adr_i)
        ADR_INSN: st_d.rdat = {8'h00, st_q.insn};
        ADR_PC: st_d.rdat = {16'h0000, st_q.pc};
        ADR_OPND: st_d.rdat = {12'h000, st_q.opnd};
        ADR_DEC: st_d.rdat = {9'h000, st_q.dec};
        ADR_TGT: st_d.rdat = st_q.tgt;
        ADR_RES: st_d.rdat = {13'h0000, st_q.res};
        ADR_IRQ: st_d.rdat = {16'h0000, 1'b0, st_q.irqCnt, 6'h00, st_q.irqDone, st_q.irqBusy};
        default: st_d.rdat = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      st_q <= '{ack: 1'b0, rdat: 32'h00000000, insn: RST_INSN, pc: RST_PC, opnd: RST_OPND,
        dec: '0, tgt: 32'h00000000, res: 19'h00000, irqCnt: 7'h00, irqBusy: 1'b0, irqDone: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdat;
  assign insnLen = st_q.dec[DEC_LEN +: 2];
  assign insnCycles = st_q.dec[DEC_CYC +: 3];
  assign branchTarget = st_q.tgt[15:0];
  assign irqVectorReady = st_q.irqDone;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstN);

  property p_muldiv;
    (op == 8'ha4 || op == 8'h84) |=> (insnLen == 2'h1 && insnCycles == 3'h4);
  endproperty
  a_muldiv: assert property (p_muldiv) else $error("multiply/divide length or cycles wrong");

  property p_extmove;
    (hi >= 4'he && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3))
      |=> (insnLen == 2'h1 && insnCycles == 3'h2 && st_q.dec[DEC_MODE +: 4] == 4'(MODE_EXT));
  endproperty
  a_extmove: assert property (p_extmove) else $error("external move decode wrong");

  property p_dptrload;
    op == 8'h90 |=> (insnLen == 2'h3 && insnCycles == 3'h2);
  endproperty
  a_dptrload: assert property (p_dptrload) else $error("pointer load decode wrong");

  property p_page;
    lo == 4'h1 |=> (st_q.tgt[15:11] == st_q.tgt[31:27] && st_q.tgt[10:8] == $past(op[7:5])
      && st_q.tgt[7:0] == $past(b2));
  endproperty
  a_page: assert property (p_page) else $error("page target wrong");

  property p_short;
    op == 8'h80 |=> st_q.tgt[15:0] == 16'($past(st_q.pc) + 16'h0002 + {{8{$past(b2[7])}}, $past(b2)});
  endproperty
  a_short: assert property (p_short) else $error("short jump target wrong");

  property p_indirect;
    (lo == 4'h6 || lo == 4'h7) |=> st_q.dec[DEC_REG +: 3] == {2'b00, $past(op[0])};
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect pointer select wrong");

  property p_swap;
    op == 8'hc4 |=> (st_q.res[7:0] == {$past(acc[3:0]), $past(acc[7:4])} && insnCycles == 3'h1);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");

  property p_rotcarry;
    op == 8'h33 |=> (st_q.res[7:0] == {$past(acc[6:0]), $past(carry)} && st_q.res[16] == $past(acc[7]));
  endproperty
  a_rotcarry: assert property (p_rotcarry) else $error("rotate through carry wrong");

  property p_bitclr;
    (op == 8'h10 && bitVal) |=> (st_q.res[17] && st_q.res[18] && insnLen == 2'h3);
  endproperty
  a_bitclr: assert property (p_bitclr) else $error("bit test and clear wrong");

  property p_addflags;
    op == 8'h24 |=> st_q.dec[DEC_FLAG +: 5] == 5'h1c;
  endproperty
  a_addflags: assert property (p_addflags) else $error("add flag effects wrong");

  property p_irqwin;
    $rose(st_q.irqBusy) |-> ##[38:81] $rose(st_q.irqDone);
  endproperty
  a_irqwin: assert property (p_irqwin) else $error("interrupt response outside window");

endmodule : bcid_decoder
`default_nettype wire

// *** shared/bcid_pkg.sv ***
// Register map, decode tables and types for the byte-code instruction decoder
package bcid_pkg;
  // Register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] ADR_INSN = 8'h00;
  localparam logic [7:0] ADR_PC = 8'h04;
  localparam logic [7:0] ADR_OPND = 8'h08;
  localparam logic [7:0] ADR_DEC = 8'h0c;
  localparam logic [7:0] ADR_TGT = 8'h10;
  localparam logic [7:0] ADR_RES = 8'h14;
  localparam logic [7:0] ADR_IRQ = 8'h18;
  // Reset values
  localparam logic [23:0] RST_INSN = 24'h000000;
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [19:0] RST_OPND = 20'h00000;
  // Decode word fields
  localparam int DEC_LEN = 0;
  localparam int DEC_CYC = 2;
  localparam int DEC_MODE = 5;
  localparam int DEC_REG = 9;
  localparam int DEC_IND = 14;
  localparam int DEC_FLAG = 15;
  localparam int DEC_REL = 21;
  localparam int DEC_VALID = 22;
  localparam int DEC_W = 23;
  // Flag effect mask bits
  localparam int FM_SETC = 0;
  localparam int FM_CLRC = 1;
  localparam int FM_UPDC = 2;
  localparam int FM_UPDOV = 3;
  localparam int FM_UPDAC = 4;
  localparam int FM_SW = 5;
  // Status word byte address and its bit-address page
  localparam logic [7:0] SW_BYTE = 8'hd0;
  localparam logic [4:0] SW_BITPAGE = 5'h1a;
  // Interrupt response window in oscillator periods, one clock per period here
  localparam logic [6:0] IRQ_MIN_OSC = 7'h26;
  localparam logic [6:0] IRQ_MAX_OSC = 7'h51;
  localparam logic [6:0] OSC_PER_MCYC = 7'h0c;
  // Length/cycle tables: one nibble per high opcode nibble, {len[1:0], cycles-1[1:0]}
  localparam logic [63:0] TBL_LO0 = 64'h559999d99999ddd4;
  localparam logic [63:0] TBL_LO1 = 64'h9999999999999999;
  localparam logic [63:0] TBL_LO2 = 64'h55888899988855dd;
  localparam logic [63:0] TBL_LO3 = 64'h554445555ddd4444;
  localparam logic [63:0] TBL_LO4 = 64'h4444d78788888844;
  localparam logic [63:0] TBL_LO5 = 64'h88d8d08dd8888888;
  localparam logic [63:0] TBL_LOI = 64'h4444d94984444444;
  localparam logic [63:0] TBL_LOR = 64'h4494d94984444444;
  // Operand addressing modes
  typedef enum logic [3:0] {
    MODE_NONE, MODE_REG, MODE_DIRECT, MODE_INDIRECT, MODE_IMM, MODE_IMM16,
    MODE_BIT, MODE_PAGE, MODE_LONG, MODE_EXT, MODE_CODE, MODE_REL
  } bcid_mode_e;
endpackage : bcid_pkg

// *** bench/bcid_seq_model.sv ***
// Execution sequencer stand-in that times the interrupt response of the decoder
`timescale 1ns/1ps
`default_nettype none
module bcid_seq_model (
  input wire logic clk_sys, // Core clock
  input wire logic arst_n, // Reset, active low
  input wire logic irqStart, // Interrupt request taken at this edge
  input wire logic irqVectorReady, // Service routine may start
  output logic [7:0] irqLatency, // Edges from request to vector
  output logic latDone // Latency captured
);
  typedef struct packed {
    logic run;
    logic done;
    logic [7:0] cnt;
    logic [7:0] lat;
  } bcid_seq_s;
  bcid_seq_s state_q, state_d;
  // Count edges while a request is pending; a new request restarts the count
  always_comb begin
    state_d = state_q;
    if (irqStart) begin
      state_d.run = 1'b1;
      state_d.done = 1'b0;
      state_d.cnt = 8'h00;
    end else if (state_q.run && irqVectorReady) begin
      state_d.run = 1'b0;
      state_d.done = 1'b1;
      state_d.lat = state_q.cnt;
    end else if (state_q.run) begin
      state_d.cnt = state_q.cnt + 8'h01; // No saturation: the bench bounds the wait
    end
  end
  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) state_q <= '0;
    else state_q <= state_d;
  end
  assign irqLatency = state_q.lat;
  assign latDone = state_q.done;
endmodule : bcid_seq_model
`default_nettype wire

// *** bench/bcid_decoder_tb.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module bcid_decoder_tb;
  import bcid_pkg::*;
  logic clkSys = 1'b0, arstN = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00, op, r2, r3, a, m;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDat = 32'h0, wbDatO, rdW, decW, tgtW, resW, rnd;
  logic wbAck, irqVectorReady, latDone, irqStart, c;
  logic [1:0] insnLen;
  logic [2:0] insnCycles;
  logic [15:0] branchTarget, rpc;
  logic [19:0] rod;
  logic [7:0] irqLatency;
  int errTotal = 0, checkCount = 0, cycCount = 0, w, seed = 32'h11e8;
  // {opcode, length, cycles}
  logic [15:0] lenTbl [0:40] = '{16'h8414, 16'ha414, 16'he012, 16'he212, 16'he312, 16'hf012, 16'hf212,
    16'hf312, 16'h9032, 16'h1032, 16'hd611, 16'hd711, 16'hc411, 16'hb432, 16'hb532, 16'hb632, 16'hbf32,
    16'hd822, 16'hdf22, 16'hd532, 16'h8312, 16'h9312, 16'h1122, 16'h1232, 16'h2212, 16'h3212, 16'h5332,
    16'h4332, 16'h6332, 16'h5811, 16'h5521, 16'h5611, 16'h3311, 16'h1311, 16'h2311, 16'h0311, 16'h0232,
    16'h0122, 16'h8022, 16'h4022, 16'h0011};
  // {opcode, second byte, flag mask}
  logic [23:0] fmTbl [0:13] = '{24'h24001c, 24'h34001c, 24'h94001c, 24'ha4000a, 24'h84000a, 24'hd40004,
    24'h330004, 24'h130004, 24'hb40004, 24'hd30001, 24'hc30002, 24'hf5d020, 24'hd2d520, 24'hf5d100};
  logic [7:0] brOps [0:5] = '{8'he1, 8'h02, 8'h80, 8'h10, 8'hd8, 8'hb4};

  bcid_decoder dut (.clk_sys(clkSys), .arst_n(arstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .insnLen(insnLen), .insnCycles(insnCycles), .branchTarget(branchTarget), .irqVectorReady(irqVectorReady));
  // Interrupt request is taken at the edge where the design accepts the write, one edge before ack is sampled
  assign irqStart = wbCyc & wbStb & wbWe & ~wbAck & (wbAdr == ADR_IRQ) & wbDat[0];
  bcid_seq_model seq (.clk_sys(clkSys), .arst_n(arstN), .irqStart(irqStart),
    .irqVectorReady(irqVectorReady), .irqLatency(irqLatency), .latDone(latDone));

  // Clock and hang guard
  initial begin
    forever #50 clkSys = ~clkSys;
  end
  always @(posedge clkSys) begin
    cycCount++;
    if (cycCount == 10000) begin
      errTotal++;
      testDone();
    end
  end

  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : testDone

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      errTotal++;
    end
  endtask : chk

  // One classic cycle; entered just after an edge, holds until ack is sampled
  task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= ad;
    wbDat <= d;
    wbSel <= 4'hf;
    do begin
      @(posedge clkSys);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    rdW = wbDatO;
    chk("ack", 32'h1, {31'h0, wbAck});
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clkSys);
  endtask : bus

  // Load an instruction with its context and read back every decode view
  task automatic dec(input logic [7:0] o, b2, b3, input logic [15:0] pc, input logic [19:0] od);
    bus(1'b1, ADR_INSN, {8'h00, b3, b2, o});
    bus(1'b1, ADR_PC, {16'h0000, pc});
    bus(1'b1, ADR_OPND, {12'h000, od});
    bus(1'b0, ADR_DEC, 32'h0);
    decW = rdW;
    bus(1'b0, ADR_TGT, 32'h0);
    tgtW = rdW;
    bus(1'b0, ADR_RES, 32'h0);
    resW = rdW;
  endtask : dec

  // Reference branch target from the addressing rules
  function automatic logic [15:0] refTgt(input logic [7:0] o, b2, b3, input logic [15:0] pc);
    logic [15:0] f2, f3;
    f2 = pc + 16'h0002;
    f3 = pc + 16'h0003;
    case (o)
      8'h02: refTgt = {b2, b3};
      8'he1: refTgt = {f2[15:11], o[7:5], b2};
      8'h80, 8'hd8: refTgt = f2 + {{8{b2[7]}}, b2};
      default: refTgt = f3 + {{8{b3[7]}}, b3};
    endcase
  endfunction : refTgt

  initial begin
    repeat (20) @(posedge clkSys);
    arstN <= 1'b1;
    repeat (4) @(posedge clkSys);
    chk("len port", 32'h1, {30'h0, insnLen});
    chk("cycles port", 32'h1, {29'h0, insnCycles});
    bus(1'b0, ADR_INSN, 32'h0);
    chk("insn reset", {8'h00, RST_INSN}, rdW);
    bus(1'b1, 8'h1c, 32'hffffffff);
    bus(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h0, rdW);
    // Length and cycle count for each documented form
    foreach (lenTbl[i]) begin
      rnd = $random(seed);
      dec(lenTbl[i][15:8], rnd[7:0], rnd[15:8], rnd[31:16], 20'h00000);
      chk("len", {28'h0, lenTbl[i][7:4]}, {30'h0, decW[1:0]});
      chk("cycles", {28'h0, lenTbl[i][3:0]}, {29'h0, decW[4:2]});
      chk("len port", {28'h0, lenTbl[i][7:4]}, {30'h0, insnLen});
      chk("cycles port", {28'h0, lenTbl[i][3:0]}, {29'h0, insnCycles});
    end
    dec(8'ha5, 8'h00, 8'h00, 16'h0000, 20'h00000);
    chk("reserved len", 32'h0, {30'h0, insnLen});
    // Flag effects, status word writes included
    foreach (fmTbl[i]) begin
      dec(fmTbl[i][23:16], fmTbl[i][15:8], 8'h00, 16'h0000, 20'h00000);
      chk("flag mask", {24'h0, fmTbl[i][7:0]}, {26'h0, decW[20:15]});
    end
    // Branch targets, page boundary and offset extremes first
    for (int k = 0; k < 6; k++) begin
      rnd = $random(seed);
      rpc = (k == 0) ? 16'h07fe : rnd[15:0];
      r2 = (k == 1) ? 8'h80 : (k == 2) ? 8'h7f : rnd[23:16];
      r3 = (k == 1) ? 8'h7f : (k == 2) ? 8'h80 : rnd[31:24];
      foreach (brOps[j]) begin
        dec(brOps[j], r2, r3, rpc, 20'h00000);
        chk("target", {16'h0, refTgt(brOps[j], r2, r3, rpc)}, {16'h0, tgtW[15:0]});
        chk("target port", {16'h0, refTgt(brOps[j], r2, r3, rpc)}, {16'h0, branchTarget});
      end
    end
    // Register and indirect operand selection in a random bank
    for (int i = 0; i < 10; i++) begin
      rod = 20'($random(seed));
      op = (i < 8) ? 8'h28 + 8'(i) : 8'he6 + 8'(i - 8);
      dec(op, 8'h00, 8'h00, 16'h0000, rod);
      chk("mode", (i < 8) ? 32'h1 : 32'h3, {28'h0, decW[8:5]});
      chk("reg", {27'h0, rod[19:18], (i < 8) ? op[2:0] : {2'b00, op[0]}}, {27'h0, decW[13:9]});
      chk("indirect", (i < 8) ? 32'h0 : 32'h1, {31'h0, decW[14]});
    end
    // Accumulator results on random operands
    repeat (4) begin
      rod = 20'($random(seed));
      a = rod[7:0];
      m = rod[15:8];
      c = rod[16];
      dec(8'hd6, 8'h00, 8'h00, 16'h0000, rod);
      chk("low nibble exchange", {16'h0, m[7:4], a[3:0], a[7:4], m[3:0]}, {16'h0, resW[15:0]});
      dec(8'hc4, 8'h00, 8'h00, 16'h0000, rod);
      chk("swap", {24'h0, a[3:0], a[7:4]}, {24'h0, resW[7:0]});
      dec(8'h33, 8'h00, 8'h00, 16'h0000, rod);
      chk("rotate left carry", {23'h0, a, c}, {23'h0, resW[16], resW[7:0]});
      dec(8'h13, 8'h00, 8'h00, 16'h0000, rod);
      chk("rotate right carry", {23'h0, a[0], c, a[7:1]}, {23'h0, resW[16], resW[7:0]});
      dec(8'h23, 8'h00, 8'h00, 16'h0000, rod);
      chk("rl", {24'h0, a[6:0], a[7]}, {24'h0, resW[7:0]});
    end
    // Bit test with clear, and compare with immediate
    for (int b = 0; b < 2; b++) begin
      dec(8'h10, 8'h20, 8'h05, 16'h0100, {2'b00, b[0], 17'h0});
      chk("bit branch", {30'h0, b[0], b[0]}, {30'h0, resW[18:17]});
      dec(8'hb4, 8'h5a, 8'h05, 16'h0100, {12'h000, b[0] ? 8'h5a : 8'h3c});
      chk("compare taken", {31'h0, ~b[0]}, {31'h0, resW[17]});
    end
    // Interrupt response after a one-cycle and a four-cycle instruction
    for (int k = 0; k < 2; k++) begin
      dec(k ? 8'ha4 : 8'h00, 8'h00, 8'h00, 16'h0000, 20'h00000);
      bus(1'b1, ADR_IRQ, 32'h00000001);
      w = 0;
      while (latDone !== 1'b1 && w < 200) begin
        @(posedge clkSys);
        w++;
      end
      chk("irq latency", k ? 32'd74 : 32'd38, {24'h0, irqLatency});
      chk("irq window", 32'h1, {31'h0, irqLatency >= 8'd38 && irqLatency <= 8'd81});
    end
    testDone();
  end
endmodule : bcid_decoder_tb
`default_nettype wire
